// ===== verilog/ippsr_pkg.sv
// Constants for the image port, power save and status register group.
// Assumes an I2C slave front end and 8-bit registers at byte subaddresses.
package ippsr_pkg;
  // Register subaddresses
  localparam logic [7:0] ADDR_CLK_PHASE_EN = 8'h87;
  localparam logic [7:0] ADDR_POWER_SAVE = 8'h88;
  localparam logic [7:0] ADDR_SCALER_STATUS = 8'h8f;
  // Reset values and writable bit masks
  localparam logic [7:0] RST_CLK_PHASE_EN = 8'h00;
  localparam logic [7:0] RST_POWER_SAVE = 8'h00;
  localparam logic [7:0] MASK_CLK_PHASE_EN = 8'hf3;
  localparam logic [7:0] MASK_POWER_SAVE = 8'hfb;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Clock phase and enable register fields
  localparam int GATED_CLK_PHASE_HI = 7;
  localparam int GATED_CLK_PHASE_LO = 6;
  localparam int IMG_CLK_PHASE_HI = 5;
  localparam int IMG_CLK_PHASE_LO = 4;
  localparam int PORT_ENABLE_B1 = 1;
  localparam int PORT_ENABLE_B0 = 0;
  // Power save register fields
  localparam int SECOND_CHANNEL_ENABLE = 7;
  localparam int FIRST_CHANNEL_ENABLE = 6;
  localparam int SCALER_SOFT_RESET = 5;
  localparam int PROGRAMMED_MARKER = 4;
  localparam int AUDIO_POWER_DOWN = 3;
  localparam int SCALER_POWER_DOWN = 1;
  localparam int DECODER_POWER_DOWN = 0;
  // Status register fields
  localparam int ST_EXPANSION_TRISTATE = 7;
  localparam int ST_IMAGE_TRISTATE = 6;
  localparam int ST_FIFO_ALMOST_FILLED = 5;
  localparam int ST_FIFO_OVERFLOW = 4;
  localparam int ST_MARKER_COPY = 3;
  // Phase code bits: bit 0 half-cycle inversion, bit 1 pad delay (~3 ns)
  localparam int PHASE_HALF_BIT = 0;
  localparam int PHASE_DELAY_BIT = 1;
  // Port enable codes
  localparam logic [1:0] PE_OFF = 2'h0;
  localparam logic [1:0] PE_SOFT = 2'h1;
  localparam logic [1:0] PE_PIN_LOW = 2'h2;
  localparam logic [1:0] PE_PIN_HIGH = 2'h3;
  // I2C slave address; value is arbitrary
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h21;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  // Control crossing width into the link domain
  localparam int LINK_CTL_W = 6;

  typedef enum {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ACK,
    I2C_SUB,
    I2C_WDATA,
    I2C_RDATA,
    I2C_RACK
  } ippsr_i2c_state_type;
endpackage

// ===== verilog/ippsr_sync2.sv
// Two flip-flop level synchroniser, one stage pair per bit.
// Assumes each bit is a level that is stable for several destination edges.
`timescale 1ns/1ps
module ippsr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        meta[i] <= d_in[i];
        stable[i] <= meta[i];
      end
    end
  endgenerate

  assign q_out = stable;
endmodule // ippsr_sync2

// ===== verilog/ippsr_link_out.sv
// Image port output stage on the image port clock.
// Assumes controls arrive as levels, registered on the register clock except the gated select from its own logic.
`timescale 1ns/1ps
module ippsr_link_out (
  input wire logic img_clk_in,
  input wire logic nrst_in,
  input wire logic [ippsr_pkg::LINK_CTL_W-1:0] ctl_in,
  input wire logic gate_in,
  output logic image_port_clock_out,
  output logic img_clk_delay_out,
  output logic data_qualifier_pin_out,
  output logic gated_clk_delay_out,
  output logic port_drive_en_out
);
  logic [ippsr_pkg::LINK_CTL_W-1:0] ctl_s;
  logic [ippsr_pkg::LINK_CTL_W-1:0] ctl_q, next_ctl_q;
  logic rst_s;
  logic ihalf, idel, ghalf, gdel, gsel, drive, gate_q;
  logic next_ihalf, next_idel, next_ghalf, next_gdel, next_gsel;
  logic next_drive, next_gate_q;

  ippsr_sync2 #(.W(ippsr_pkg::LINK_CTL_W)) u_ctl_sync (
    .clk_in(img_clk_in),
    .d_in(ctl_in),
    .q_out(ctl_s)
  );
  ippsr_sync2 #(.W(1)) u_rst_sync (
    .clk_in(img_clk_in),
    .d_in(nrst_in),
    .q_out(rst_s)
  );

  // ctl: [5:4] gated phase, [3:2] image phase, [1] gated select, [0] enable
  always_comb begin
    next_ctl_q = ctl_s;
    next_ihalf = ihalf;
    next_idel = idel;
    next_gsel = gsel;
    next_ghalf = ghalf;
    next_gdel = gdel;
    next_drive = drive;
    next_gate_q = gate_in;
    // Take the word only once two samples agree: bits of one field may land
    // an edge apart and must never show a code that was not written
    if (ctl_s == ctl_q) begin
      next_ihalf = ctl_s[2 + ippsr_pkg::PHASE_HALF_BIT];
      next_idel = ctl_s[2 + ippsr_pkg::PHASE_DELAY_BIT];
      next_gsel = ctl_s[1];
      // Gated phase only takes effect with the gated clock selected
      next_ghalf = ctl_s[1] &
        ctl_s[4 + ippsr_pkg::PHASE_HALF_BIT];
      next_gdel = ctl_s[1] &
        ctl_s[4 + ippsr_pkg::PHASE_DELAY_BIT];
      next_drive = ctl_s[0];
    end
    if (!rst_s) begin
      next_ihalf = 1'b0;
      next_idel = 1'b0;
      next_gsel = 1'b0;
      next_ghalf = 1'b0;
      next_gdel = 1'b0;
      next_drive = 1'b0;
      next_gate_q = 1'b0;
    end
  end

  always_ff @(posedge img_clk_in) begin
    ctl_q <= next_ctl_q;
    ihalf <= next_ihalf;
    idel <= next_idel;
    ghalf <= next_ghalf;
    gdel <= next_gdel;
    gsel <= next_gsel;
    drive <= next_drive;
    gate_q <= next_gate_q;
  end

  // Half-cycle shift is an inversion; the delay flag steers a pad delay cell
  assign image_port_clock_out = img_clk_in ^ ihalf;
  assign img_clk_delay_out = idel;
  assign data_qualifier_pin_out = gsel ? ((img_clk_in ^ ghalf) & gate_q) :
                                  gate_q;
  assign gated_clk_delay_out = gdel;
  assign port_drive_en_out = drive;
endmodule // ippsr_link_out

// ===== verilog/ippsr_top.sv
// Image port control, power save and scaler status registers behind I2C.
// Assumes SCL/SDA and tri-state pins are asynchronous; FIFO flags, select
// bits and the qualifier gate come from logic on their own clocks.
`timescale 1ns/1ps
module ippsr_top (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic img_clk_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic image_tristate_pin_in,
  input wire logic expansion_tristate_pin_in,
  input wire logic fifo_almost_filled_in,
  input wire logic fifo_overflow_in,
  input wire logic gated_clk_select_in,
  input wire logic scaler_src_xport_in,
  input wire logic image_port_clock_src_xport_in,
  input wire logic gate_in,
  output logic image_port_clock_out,
  output logic img_clk_delay_out,
  output logic data_qualifier_pin_out,
  output logic gated_clk_delay_out,
  output logic port_drive_en_out,
  output logic first_channel_enable_out,
  output logic second_channel_enable_out,
  output logic scaler_reset_n_out,
  output logic scaler_run_out,
  output logic decoder_power_down_out,
  output logic scaler_power_down_out,
  output logic audio_power_down_out
);
  // Synchronised pins: [3] scl, [2] sda, [1] expansion tri, [0] image tri
  logic [3:0] pin_s;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, start_c, stop_c;

  ippsr_sync2 #(.W(4)) u_pin_sync (
    .clk_in(ref_clk_in),
    .d_in({scl_in, sda_in, expansion_tristate_pin_in,
           image_tristate_pin_in}),
    .q_out(pin_s)
  );

  always_ff @(posedge ref_clk_in) begin
    scl_q <= pin_s[3];
    sda_q <= pin_s[2];
  end

  assign scl_rise = pin_s[3] & ~scl_q;
  assign scl_fall = ~pin_s[3] & scl_q;
  assign start_c = pin_s[3] & scl_q & sda_q & ~pin_s[2];
  assign stop_c = pin_s[3] & scl_q & ~sda_q & pin_s[2];

  // Register file
  logic [7:0] clk_phase_en, power_save;
  logic [7:0] next_clk_phase_en, next_power_save;
  logic port_en, next_port_en;
  logic [7:0] status_byte;
  logic wr_en;
  logic [7:0] wr_data;

  // I2C state
  ippsr_pkg::ippsr_i2c_state_type st, next_st, ack_to, next_ack_to;
  logic [3:0] cnt, next_cnt;
  logic [7:0] sr, next_sr, tx, next_tx, sub, next_sub;
  logic have_sub, next_have_sub, nack, next_nack, drive, next_drive;
  logic [7:0] rd_byte;

  // Live status: captured only when a byte is loaded for transmission
  always_comb begin
    status_byte = 8'h00;
    status_byte[ippsr_pkg::ST_EXPANSION_TRISTATE] = pin_s[1];
    status_byte[ippsr_pkg::ST_IMAGE_TRISTATE] = pin_s[0];
    status_byte[ippsr_pkg::ST_FIFO_ALMOST_FILLED] =
      fifo_almost_filled_in;
    status_byte[ippsr_pkg::ST_FIFO_OVERFLOW] = fifo_overflow_in;
    status_byte[ippsr_pkg::ST_MARKER_COPY] =
      power_save[ippsr_pkg::PROGRAMMED_MARKER];
  end

  always_comb begin
    case (sub)
      ippsr_pkg::ADDR_CLK_PHASE_EN: rd_byte = clk_phase_en;
      ippsr_pkg::ADDR_POWER_SAVE: rd_byte = power_save;
      ippsr_pkg::ADDR_SCALER_STATUS: rd_byte = status_byte;
      default: rd_byte = ippsr_pkg::READ_UNMAPPED;
    endcase
  end

  // I2C slave next state
  always_comb begin
    next_st = st;
    next_ack_to = ack_to;
    next_cnt = cnt;
    next_sr = sr;
    next_tx = tx;
    next_sub = sub;
    next_have_sub = have_sub;
    next_nack = nack;
    next_drive = drive;
    wr_en = 1'b0;
    wr_data = sr;
    if (scl_rise && st != ippsr_pkg::I2C_IDLE) begin
      next_sr = {sr[6:0], pin_s[2]};
      next_cnt = cnt + 4'h1;
      if (st == ippsr_pkg::I2C_RACK) begin
        next_nack = pin_s[2];
      end
    end
    if (scl_fall) begin
      case (st)
        ippsr_pkg::I2C_ADDR: begin
          if (cnt == ippsr_pkg::I2C_BYTE_BITS) begin
            if (sr[7:1] == ippsr_pkg::I2C_SLAVE_ADDR) begin
              next_st = ippsr_pkg::I2C_ACK;
              next_drive = 1'b1;
              next_ack_to = sr[0] ? ippsr_pkg::I2C_RDATA :
                            ippsr_pkg::I2C_SUB;
            end else begin
              next_st = ippsr_pkg::I2C_IDLE;
            end
          end
        end
        ippsr_pkg::I2C_SUB: begin
          if (cnt == ippsr_pkg::I2C_BYTE_BITS) begin
            next_sub = sr;
            next_have_sub = 1'b1;
            next_st = ippsr_pkg::I2C_ACK;
            next_drive = 1'b1;
            next_ack_to = ippsr_pkg::I2C_WDATA;
          end
        end
        ippsr_pkg::I2C_WDATA: begin
          if (cnt == ippsr_pkg::I2C_BYTE_BITS) begin
            wr_en = 1'b1;
            next_sub = sub + 8'h01;
            next_st = ippsr_pkg::I2C_ACK;
            next_drive = 1'b1;
            next_ack_to = ippsr_pkg::I2C_WDATA;
          end
        end
        ippsr_pkg::I2C_ACK: begin
          next_cnt = 4'h0;
          next_drive = 1'b0;
          next_st = ack_to;
          if (ack_to == ippsr_pkg::I2C_RDATA) begin
            next_drive = ~rd_byte[7];
            next_tx = {rd_byte[6:0], 1'b0};
          end
        end
        ippsr_pkg::I2C_RDATA: begin
          if (cnt == ippsr_pkg::I2C_BYTE_BITS) begin
            next_drive = 1'b0;
            next_st = ippsr_pkg::I2C_RACK;
            next_sub = sub + 8'h01;
          end else begin
            next_drive = ~tx[7];
            next_tx = {tx[6:0], 1'b0};
          end
        end
        ippsr_pkg::I2C_RACK: begin
          if (cnt != 4'h0) begin
            next_cnt = 4'h0;
            if (nack) begin
              next_st = ippsr_pkg::I2C_IDLE;
              next_drive = 1'b0;
            end else begin
              next_st = ippsr_pkg::I2C_RDATA;
              next_drive = ~rd_byte[7];
              next_tx = {rd_byte[6:0], 1'b0};
            end
          end
        end
        default: begin
          next_st = st;
        end
      endcase
    end
    if (start_c) begin
      next_st = ippsr_pkg::I2C_ADDR;
      next_cnt = 4'h0;
      next_have_sub = 1'b0;
      next_drive = 1'b0;
    end else if (stop_c) begin
      next_st = ippsr_pkg::I2C_IDLE;
      next_drive = 1'b0;
    end
    if (!nrst_in) begin
      next_st = ippsr_pkg::I2C_IDLE;
      next_ack_to = ippsr_pkg::I2C_IDLE;
      next_cnt = 4'h0;
      next_sr = 8'h00;
      next_tx = 8'h00;
      next_sub = 8'h00;
      next_have_sub = 1'b0;
      next_nack = 1'b0;
      next_drive = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st <= next_st;
    ack_to <= next_ack_to;
    cnt <= next_cnt;
    sr <= next_sr;
    tx <= next_tx;
    sub <= next_sub;
    have_sub <= next_have_sub;
    nack <= next_nack;
    drive <= next_drive;
  end

  // Register writes and the registered port enable term
  always_comb begin
    next_clk_phase_en = clk_phase_en;
    next_power_save = power_save;
    if (wr_en && sub == ippsr_pkg::ADDR_CLK_PHASE_EN) begin
      next_clk_phase_en = wr_data & ippsr_pkg::MASK_CLK_PHASE_EN;
    end
    if (wr_en && sub == ippsr_pkg::ADDR_POWER_SAVE) begin
      next_power_save = wr_data & ippsr_pkg::MASK_POWER_SAVE;
    end
    case (clk_phase_en[ippsr_pkg::PORT_ENABLE_B1:
                       ippsr_pkg::PORT_ENABLE_B0])
      ippsr_pkg::PE_OFF: next_port_en = 1'b0;
      ippsr_pkg::PE_SOFT: next_port_en = 1'b1;
      ippsr_pkg::PE_PIN_LOW: next_port_en = ~pin_s[0];
      ippsr_pkg::PE_PIN_HIGH: next_port_en = pin_s[0];
      default: next_port_en = 1'b0;
    endcase
    if (power_save[ippsr_pkg::SCALER_POWER_DOWN]) begin
      next_port_en = 1'b0;
    end
    if (!nrst_in) begin
      next_clk_phase_en = ippsr_pkg::RST_CLK_PHASE_EN;
      next_power_save = ippsr_pkg::RST_POWER_SAVE;
      next_port_en = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    clk_phase_en <= next_clk_phase_en;
    power_save <= next_power_save;
    port_en <= next_port_en;
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = drive;

  ippsr_link_out u_link (
    .img_clk_in(img_clk_in),
    .nrst_in(nrst_in),
    .ctl_in({clk_phase_en[ippsr_pkg::GATED_CLK_PHASE_HI:
                          ippsr_pkg::GATED_CLK_PHASE_LO],
             clk_phase_en[ippsr_pkg::IMG_CLK_PHASE_HI:
                          ippsr_pkg::IMG_CLK_PHASE_LO],
             gated_clk_select_in, port_en}),
    .gate_in(gate_in),
    .image_port_clock_out(image_port_clock_out),
    .img_clk_delay_out(img_clk_delay_out),
    .data_qualifier_pin_out(data_qualifier_pin_out),
    .gated_clk_delay_out(gated_clk_delay_out),
    .port_drive_en_out(port_drive_en_out)
  );

  assign first_channel_enable_out =
    power_save[ippsr_pkg::FIRST_CHANNEL_ENABLE];
  assign second_channel_enable_out =
    power_save[ippsr_pkg::SECOND_CHANNEL_ENABLE];
  assign scaler_reset_n_out = power_save[ippsr_pkg::SCALER_SOFT_RESET];
  assign decoder_power_down_out =
    power_save[ippsr_pkg::DECODER_POWER_DOWN];
  assign scaler_power_down_out =
    power_save[ippsr_pkg::SCALER_POWER_DOWN];
  assign audio_power_down_out =
    power_save[ippsr_pkg::AUDIO_POWER_DOWN];
  // With the decoder down the scaler needs both sources on the expansion port
  assign scaler_run_out = power_save[ippsr_pkg::SCALER_SOFT_RESET] &
    ~power_save[ippsr_pkg::SCALER_POWER_DOWN] &
    (~power_save[ippsr_pkg::DECODER_POWER_DOWN] |
     (scaler_src_xport_in & image_port_clock_src_xport_in));
endmodule // ippsr_top

// ===== bench/ippsr_props.sv
// Port checks for the register group top, attached to it by bind.
// Assumes the bench keeps gate_in low and stable across every reset.
`timescale 1ns/1ps
module ippsr_props (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic img_clk_in,
  input wire logic scl_in,
  input wire logic sda_oe_out,
  input wire logic gated_clk_select_in,
  input wire logic scaler_src_xport_in,
  input wire logic image_port_clock_src_xport_in,
  input wire logic gate_in,
  input wire logic data_qualifier_pin_out,
  input wire logic gated_clk_delay_out,
  input wire logic port_drive_en_out,
  input wire logic first_channel_enable_out,
  input wire logic scaler_reset_n_out,
  input wire logic scaler_run_out,
  input wire logic decoder_power_down_out,
  input wire logic scaler_power_down_out,
  input wire logic audio_power_down_out
);
  reset_clears_a: assert property (@(posedge ref_clk_in)
    !nrst_in |=> !scaler_reset_n_out && !scaler_run_out
      && !first_channel_enable_out && !audio_power_down_out)
    else $error("outputs not cleared by reset");
  soft_reset_idle_a: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) !scaler_reset_n_out |-> !scaler_run_out)
    else $error("scaler runs while held in soft reset");
  scaler_down_a: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) scaler_power_down_out |-> !scaler_run_out)
    else $error("scaler runs while powered down");
  decoder_xport_a: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) decoder_power_down_out
      && !(scaler_src_xport_in && image_port_clock_src_xport_in) |-> !scaler_run_out)
    else $error("scaler runs without expansion port sources");
  port_stopped_a: assert property (@(posedge img_clk_in)
    disable iff (!nrst_in) scaler_power_down_out[*6] |-> !port_drive_en_out)
    else $error("image port driven while scaler powered down");
  gated_ignored_a: assert property (@(posedge img_clk_in)
    disable iff (!nrst_in)
      (!gated_clk_select_in)[*6] |-> !gated_clk_delay_out)
    else $error("gated delay active without gated select");
  qualifier_plain_a: assert property (@(posedge img_clk_in)
    disable iff (!nrst_in) (!gated_clk_select_in)[*6]
      |-> data_qualifier_pin_out == $past(gate_in))
    else $error("qualifier not plain gate without gated select");
  sda_scl_low_a: assert property (@(posedge ref_clk_in)
    disable iff (!nrst_in) $changed(sda_oe_out) |-> !scl_in)
    else $error("data line changed while clock high");
  cover property (@(posedge ref_clk_in) $rose(scaler_run_out));
  cover property (@(posedge img_clk_in) $rose(port_drive_en_out));
  cover property (@(posedge ref_clk_in) $rose(sda_oe_out));
endmodule // ippsr_props

bind ippsr_top ippsr_props i_props (.*);

// ===== bench/ippsr_gfx_model.sv
// Graphics controller model on the far side of the image port.
// Assumes it makes the free-running image clock that the port runs on.
`timescale 1ns/1ps
module ippsr_gfx_model (
  input wire logic data_qualifier_in,
  input wire logic port_drive_en_in,
  input wire logic clear_in,
  output logic img_clk_out,
  output int qual_edges_out
);
  initial begin
    img_clk_out = 1'b0;
    #3.3;
    forever #62.5 img_clk_out = ~img_clk_out;
  end
  // Qualifier edges reach the controller only while the port drives
  always @(posedge data_qualifier_in or posedge clear_in) begin
    if (clear_in) begin
      qual_edges_out <= 0;
    end else if (port_drive_en_in) begin
      qual_edges_out <= qual_edges_out + 1;
    end
  end
endmodule // ippsr_gfx_model

// ===== bench/ippsr_top_tb.sv
// Self-checking bench for the image port and power save register group.
// Assumes a bit-banged I2C master here and the image clock from the model.
`timescale 1ns/1ps
`define CHECK(g, e, m) begin n_compared++; if ((g) !== (e)) begin \
  fails++; $display("MISMATCH %0t %s", $time, m); end end
module ippsr_top_tb;
  logic ref_clk_in, nrst_in, img_clk_in, scl_in, sda_drv, sda_out, sda_oe_out;
  logic image_tristate_pin_in, expansion_tristate_pin_in, clr;
  logic fifo_almost_filled_in, fifo_overflow_in, gated_clk_select_in;
  logic scaler_src_xport_in, image_port_clock_src_xport_in, gate_in;
  logic image_port_clock_out, img_clk_delay_out, data_qualifier_pin_out;
  logic gated_clk_delay_out, port_drive_en_out, first_channel_enable_out;
  logic second_channel_enable_out, scaler_reset_n_out, scaler_run_out;
  logic decoder_power_down_out, scaler_power_down_out, audio_power_down_out;
  int fails = 0, n_compared = 0, qual;
  wire sda_line = sda_drv & (sda_oe_out ? sda_out : 1'b1);
  ippsr_top i_dut (.*, .sda_in(sda_line));
  ippsr_gfx_model i_gfx (.data_qualifier_in(data_qualifier_pin_out),
    .port_drive_en_in(port_drive_en_out), .clear_in(clr),
    .img_clk_out(img_clk_in), .qual_edges_out(qual));
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic hp();
    repeat (4) @(negedge ref_clk_in);
  endtask
  task automatic bit_c(input logic b, output logic r);
    hp();
    sda_drv = b;
    hp();
    scl_in = 1'b1;
    hp();
    hp();
    r = sda_line;
    scl_in = 1'b0;
  endtask
  task automatic start_c();
    hp();
    sda_drv = 1'b1;
    hp();
    scl_in = 1'b1;
    hp();
    sda_drv = 1'b0;
    hp();
    scl_in = 1'b0;
  endtask
  task automatic stop_c();
    hp();
    sda_drv = 1'b0;
    hp();
    scl_in = 1'b1;
    hp();
    sda_drv = 1'b1;
    hp();
  endtask
  task automatic byte_c(input logic [7:0] tx, input logic ea,
                        output logic [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) bit_c(tx[i], rx[i]);
    bit_c(1'b1, a);
    `CHECK(a, ea, "acknowledge bit")
  endtask
  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic [7:0] x;
    start_c();
    byte_c({ippsr_pkg::I2C_SLAVE_ADDR, 1'b0}, 1'b0, x);
    byte_c(sub, 1'b0, x);
    byte_c(d, 1'b0, x);
    stop_c();
  endtask
  task automatic rd_chk(input logic [7:0] sub, input logic [7:0] exp);
    logic [7:0] x;
    start_c();
    byte_c({ippsr_pkg::I2C_SLAVE_ADDR, 1'b0}, 1'b0, x);
    byte_c(sub, 1'b0, x);
    start_c();
    byte_c({ippsr_pkg::I2C_SLAVE_ADDR, 1'b1}, 1'b0, x);
    byte_c(8'hff, 1'b1, x);
    stop_c();
    `CHECK(x, exp, "register read")
  endtask
  task automatic lw();
    repeat (6) @(negedge img_clk_in);
    @(negedge ref_clk_in);
  endtask
  task automatic do_reset();
    nrst_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    repeat (3) @(posedge img_clk_in);
    @(negedge ref_clk_in);
    nrst_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    fails++;
    conclude();
  end
  initial begin
    logic e;
    {scl_in, sda_drv, clr} = 3'b110;
    {image_tristate_pin_in, expansion_tristate_pin_in} = 2'b00;
    {fifo_almost_filled_in, fifo_overflow_in, gate_in} = 3'b000;
    {gated_clk_select_in, scaler_src_xport_in, image_port_clock_src_xport_in} = 3'b000;
    do_reset();
    rd_chk(ippsr_pkg::ADDR_CLK_PHASE_EN, 8'h00);
    rd_chk(ippsr_pkg::ADDR_POWER_SAVE, 8'h00);
    `CHECK(scaler_reset_n_out, 1'b0, "scaler not held")
    $display("test reset values done");
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'hff);
    rd_chk(ippsr_pkg::ADDR_POWER_SAVE, 8'hfb);
    `CHECK({second_channel_enable_out, first_channel_enable_out, audio_power_down_out}, 3'b111, "power bits")
    rd_chk(ippsr_pkg::ADDR_SCALER_STATUS, 8'h08);
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h31);
    `CHECK(scaler_run_out, 1'b0, "run without xport")
    {scaler_src_xport_in, image_port_clock_src_xport_in} = 2'b11;
    @(negedge ref_clk_in);
    `CHECK(scaler_run_out, 1'b1, "run from xport")
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h33);
    `CHECK(scaler_run_out, 1'b0, "run while scaler down")
    `CHECK(scaler_power_down_out, 1'b1, "scaler down")
    `CHECK(decoder_power_down_out, 1'b1, "decoder down")
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h10);
    `CHECK({scaler_run_out, audio_power_down_out, first_channel_enable_out}, 3'b000, "idle")
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h30);
    `CHECK(scaler_run_out, 1'b1, "run after soft reset")
    $display("test power save done");
    for (int i = 0; i < 16; i++) begin
      {expansion_tristate_pin_in, image_tristate_pin_in} = i[3:2];
      {fifo_almost_filled_in, fifo_overflow_in} = i[1:0];
      repeat (4) @(negedge ref_clk_in);
      rd_chk(ippsr_pkg::ADDR_SCALER_STATUS, {i[3:0], 4'h8});
    end
    wr(ippsr_pkg::ADDR_SCALER_STATUS, 8'h00);
    rd_chk(ippsr_pkg::ADDR_SCALER_STATUS, 8'hf8);
    rd_chk(8'h90, 8'h00);
    wr(ippsr_pkg::ADDR_CLK_PHASE_EN, 8'hff);
    rd_chk(ippsr_pkg::ADDR_CLK_PHASE_EN, 8'hf3);
    $display("test status done");
    for (int c = 0; c < 8; c++) begin
      image_tristate_pin_in = c[2];
      wr(ippsr_pkg::ADDR_CLK_PHASE_EN, {6'h00, c[1:0]});
      lw();
      e = c[1:0] == 2'd1 || (c[1:0] == 2'd2 && !c[2]) || (c[1:0] == 2'd3 && c[2]);
      `CHECK(port_drive_en_out, e, "port enable code")
    end
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h32);
    lw();
    `CHECK(port_drive_en_out, 1'b0, "port on while scaler down")
    wr(ippsr_pkg::ADDR_POWER_SAVE, 8'h30);
    $display("test port enable done");
    {gated_clk_select_in, gate_in} = 2'b11;
    for (int c = 0; c < 4; c++) begin
      // Half-cycle code 01 is the recommended one for both clocks
      wr(ippsr_pkg::ADDR_CLK_PHASE_EN, {c[1:0], c[1:0], 4'h1});
      lw();
      `CHECK({img_clk_delay_out, gated_clk_delay_out}, {2{c[1]}}, "delays")
      repeat (2) begin
        `CHECK(image_port_clock_out, img_clk_in ^ c[0], "image clock")
        `CHECK(data_qualifier_pin_out, img_clk_in ^ c[0], "gated clock")
        repeat (9) @(negedge ref_clk_in);
      end
    end
    clr = 1'b1;
    @(negedge ref_clk_in);
    clr = 1'b0;
    repeat (10) @(posedge img_clk_in);
    `CHECK(qual >= 9, 1'b1, "gated clock edges")
    @(negedge ref_clk_in);
    gated_clk_select_in = 1'b0;
    lw();
    `CHECK({gated_clk_delay_out, data_qualifier_pin_out}, 2'b01, "plain")
    $display("test clock phase done");
    {gate_in, image_tristate_pin_in, expansion_tristate_pin_in} = 3'b000;
    {fifo_almost_filled_in, fifo_overflow_in} = 2'b00;
    lw();
    do_reset();
    rd_chk(ippsr_pkg::ADDR_SCALER_STATUS, 8'h00);
    `CHECK(scaler_reset_n_out, 1'b0, "scaler not held again")
    $display("test second reset done");
    conclude();
  end
endmodule // ippsr_top_tb
